// ### design/hotplug_pkg.sv
// shared constants for the live insertion slot controller
`default_nettype none
package hotplug_pkg;
  localparam int NSLOT = 4;
  // clock and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int T_POWER_NS    = 1000;
  localparam int T_RESET_NS    = 1000;
  localparam int T_LINK_NS     = 400;
  localparam int BLINK_HALF_NS = 250000000;
  localparam logic [15:0] T_POWER_CYC =
    16'((T_POWER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] T_RESET_CYC =
    16'((T_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] T_LINK_CYC =
    16'((T_LINK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
  // configuration space offsets (byte addresses)
  localparam logic [7:0] CFG_ID_OFF    = 8'h00;
  localparam logic [7:0] CFG_MISC_OFF  = 8'h40;
  localparam logic [7:0] CFG_INDEX_OFF = 8'h50;
  localparam logic [7:0] CFG_DATA_OFF  = 8'h54;
  localparam int MISC_WINDOW_EN_BIT = 23;
  localparam int MISC_SETUP_66_BIT  = 0;
  localparam logic [31:0] MISC_RESET = 32'h0000_0000;
  // device numbers per segment
  localparam logic [4:0] DEV_SEG_A = 5'h07;
  localparam logic [4:0] DEV_SEG_B = 5'h05;
  // arbitrary identification value, names no real maker
  localparam logic [31:0] ID_VALUE = 32'h0001_0001;
  // indexed hot-plug registers
  localparam logic [7:0] IDX_SLOT_POWER_ENABLE = 8'h00;
  localparam logic [7:0] IDX_SLOT_INDICATOR    = 8'h04;
  localparam logic [7:0] IDX_SLOT_STATUS       = 8'h08;
  localparam int COMMIT_BIT     = 16;
  localparam int STAT_POWER_LSB = 4;
  localparam int STAT_FAULT_LSB = 8;
  localparam int STAT_SPDERR_BIT = 12;
  localparam int STAT_BUS66_BIT  = 13;
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [3:0] SLOT_RESET  = 4'h0;
  // per slot sequence, gray along power-up then power-down path except the step from ST_PWROFF back to ST_OFF
  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_PWRUP   = 3'b001,
    ST_CONNECT = 3'b011,
    ST_ON      = 3'b010,
    ST_RSTDN   = 3'b110,
    ST_DISC    = 3'b111,
    ST_PWROFF  = 3'b101
  } slot_state_e;
endpackage
`default_nettype wire

// ### design/live_insertion_controller.sv
// live insertion slot controller: config window, slot sequencing, indicators, speed
`default_nettype none
// Notes on behaviour
// - sequence is power first, bus connected last, reverse on removal; a fault drops power and bus together.
// - dual-speed segment powers first; other segment waits for peer done.
// - empty bus uses setup speed; 33 card on 66 bus drops, flags error.
// - second segment always runs at 33 MHz.
// - each slot drives a green power and an amber attention indicator.
// - green shows power, amber shows attention, independently combined.
// - button starts power change; green blinks, amber off meanwhile.
// - hardware button acts like software power command.
// - button on empty slot toggles power without any driver.
// - over-current or under-voltage raises fault and removes power.
// - mechanical interlock is taken as permanently asserted.
// - new card held in reset, released after connection settles.
// - controller connects and disconnects slot bus signals itself.
// - dummy bus cycles are generated during slot transitions.
// - config space answers as device 7 on segment A, 5 on B.
// - index/data window only works after misc bit 23 is set.
// - hot-plug registers reached by index at 50h and data at 54h.
// - slot enable at index 00, indicator control at index 04.
// - slot controls reach outputs only after commit bit 16 write.
module live_insertion_controller #(
  parameter int unsigned BLINK_HALF_CYC = hotplug_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  // configuration access
  input  wire logic        CFG_REQ,
  input  wire logic        CFG_WR,
  input  wire logic [4:0]  CFG_DEV,
  input  wire logic [7:0]  CFG_ADDR,
  input  wire logic [3:0]  CFG_BE,
  input  wire logic [31:0] CFG_WDATA,
  output logic      [31:0] CFG_RDATA,
  output logic             CFG_ACK,
  // board straps and peer
  input  wire logic        SEGMENT_B_SEL,
  input  wire logic        PEER_INIT_DONE,
  output logic             INIT_DONE,
  // slot pins
  input  wire logic [3:0]  SLOT_BUTTON_N,
  input  wire logic [3:0]  SLOT_PRESENT,
  input  wire logic [3:0]  SLOT_FAULT,
  input  wire logic [3:0]  SLOT_M66EN,
  output logic      [3:0]  SLOT_POWER_EN,
  output logic      [3:0]  SLOT_BUS_CONNECT,
  output logic      [3:0]  SLOT_RESET_N,
  output logic      [3:0]  LED_GREEN,
  output logic      [3:0]  LED_AMBER,
  // bus level
  output logic             DUMMY_CYCLE_EN,
  output logic             BUS_66_EN,
  output logic             SPEED_ERROR
);
  localparam int NS = hotplug_pkg::NSLOT;
  localparam int NPIN = 4 * NS + 2;

  function automatic logic [31:0] merge_be(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_linked(input hotplug_pkg::slot_state_e s);
    return (s == hotplug_pkg::ST_CONNECT) || (s == hotplug_pkg::ST_ON) ||
           (s == hotplug_pkg::ST_RSTDN);
  endfunction

  // pin synchronisers
  logic [NPIN-1:0] meta_reg;
  logic [NPIN-1:0] sync_reg;
  logic [NS-1:0]   button_prev_reg;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      meta_reg        <= '0;
      sync_reg        <= '0;
      // low, so the synchroniser filling up after release cannot fake a press
      button_prev_reg <= '0;
    end else begin
      meta_reg        <= {PEER_INIT_DONE, SEGMENT_B_SEL, SLOT_M66EN, SLOT_FAULT,
                          SLOT_PRESENT, SLOT_BUTTON_N};
      sync_reg        <= meta_reg;
      button_prev_reg <= sync_reg[NS-1:0];
    end
  end

  logic [NS-1:0] button_n;
  logic [NS-1:0] present;
  logic [NS-1:0] fault_pin;
  logic [NS-1:0] m66;
  logic          seg_strap;
  logic          peer_done;
  logic [NS-1:0] press;
  assign button_n  = sync_reg[NS-1:0];
  assign present   = sync_reg[2*NS-1:NS];
  assign fault_pin = sync_reg[3*NS-1:2*NS];
  assign m66       = sync_reg[4*NS-1:3*NS];
  assign seg_strap = sync_reg[4*NS];
  assign peer_done = sync_reg[4*NS+1];
  assign press     = button_prev_reg & ~button_n;

  // strap caught after release, once the synchroniser has filled
  logic [1:0] strap_cnt_reg;
  logic       seg_b_reg;
  logic       init_ok_reg;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      strap_cnt_reg <= 2'h0;
      seg_b_reg     <= 1'b0;
      init_ok_reg   <= 1'b0;
    end else begin
      if (strap_cnt_reg != 2'h3) begin
        strap_cnt_reg <= strap_cnt_reg + 2'h1;
        seg_b_reg     <= seg_strap;
      end else if (!seg_b_reg || peer_done) begin
        init_ok_reg <= 1'b1;
      end
    end
  end

  // configuration space
  logic [31:0] misc_reg;
  logic [7:0]  index_reg;
  logic [NS-1:0] pend_enable_reg;
  logic [NS-1:0] pend_amber_reg;
  logic [NS-1:0] target_reg;
  logic [NS-1:0] amber_cmt_reg;
  logic [NS-1:0] fault_lat_reg;
  logic          commit_seen_reg;
  logic          bus_66_reg;
  logic          spd_err_reg;
  hotplug_pkg::slot_state_e state_reg [NS];
  logic [15:0]   timer_reg [NS];

  logic        hit;
  logic        window_on;
  logic        data_acc;
  logic        data_wr;
  logic        commit;
  logic [31:0] win_rdata;
  logic [NS-1:0] power_now;
  logic [NS-1:0] fault_now;
  logic [NS-1:0] fault_clr;
  logic          spd_clr;
  always_comb begin
    hit = CFG_REQ && (CFG_DEV == (seg_b_reg ? hotplug_pkg::DEV_SEG_B
                                            : hotplug_pkg::DEV_SEG_A));
    window_on = misc_reg[hotplug_pkg::MISC_WINDOW_EN_BIT];
    data_acc  = hit && window_on && (CFG_ADDR[7:2] == hotplug_pkg::CFG_DATA_OFF[7:2]);
    data_wr   = data_acc && CFG_WR;
    commit    = data_wr && (index_reg == hotplug_pkg::IDX_SLOT_POWER_ENABLE) &&
                CFG_BE[2] && CFG_WDATA[hotplug_pkg::COMMIT_BIT];
    fault_clr = '0;
    spd_clr   = 1'b0;
    if (data_wr && (index_reg == hotplug_pkg::IDX_SLOT_STATUS) && CFG_BE[1]) begin
      fault_clr = CFG_WDATA[hotplug_pkg::STAT_FAULT_LSB +: NS];
      spd_clr   = CFG_WDATA[hotplug_pkg::STAT_SPDERR_BIT];
    end
    for (int i = 0; i < NS; i++) begin
      power_now[i] = state_reg[i] != hotplug_pkg::ST_OFF;
      fault_now[i] = power_now[i] && fault_pin[i];
    end
    win_rdata = 32'h0000_0000;
    if (index_reg == hotplug_pkg::IDX_SLOT_POWER_ENABLE) begin
      win_rdata[NS-1:0] = pend_enable_reg;
    end else if (index_reg == hotplug_pkg::IDX_SLOT_INDICATOR) begin
      win_rdata[NS-1:0] = pend_amber_reg;
    end else if (index_reg == hotplug_pkg::IDX_SLOT_STATUS) begin
      win_rdata[NS-1:0] = present;
      win_rdata[hotplug_pkg::STAT_POWER_LSB +: NS] = power_now;
      win_rdata[hotplug_pkg::STAT_FAULT_LSB +: NS] = fault_lat_reg;
      win_rdata[hotplug_pkg::STAT_SPDERR_BIT] = spd_err_reg;
      win_rdata[hotplug_pkg::STAT_BUS66_BIT]  = bus_66_reg;
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      misc_reg        <= hotplug_pkg::MISC_RESET;
      index_reg       <= hotplug_pkg::INDEX_RESET;
      pend_enable_reg <= hotplug_pkg::SLOT_RESET;
      pend_amber_reg  <= hotplug_pkg::SLOT_RESET;
      CFG_RDATA       <= 32'h0000_0000;
      CFG_ACK         <= 1'b0;
    end else begin
      CFG_ACK   <= hit;
      CFG_RDATA <= 32'h0000_0000;
      if (hit && CFG_WR) begin
        if (CFG_ADDR[7:2] == hotplug_pkg::CFG_MISC_OFF[7:2]) begin
          misc_reg <= merge_be(misc_reg, CFG_WDATA, CFG_BE);
        end else if (CFG_ADDR[7:2] == hotplug_pkg::CFG_INDEX_OFF[7:2] && window_on) begin
          if (CFG_BE[0]) begin
            index_reg <= CFG_WDATA[7:0];
          end
        end
      end else if (hit) begin
        if (CFG_ADDR[7:2] == hotplug_pkg::CFG_ID_OFF[7:2]) begin
          CFG_RDATA <= hotplug_pkg::ID_VALUE;
        end else if (CFG_ADDR[7:2] == hotplug_pkg::CFG_MISC_OFF[7:2]) begin
          CFG_RDATA <= misc_reg;
        end else if (CFG_ADDR[7:2] == hotplug_pkg::CFG_INDEX_OFF[7:2] && window_on) begin
          CFG_RDATA <= {24'h00_0000, index_reg};
        end else if (data_acc) begin
          CFG_RDATA <= win_rdata;
        end
      end
      if (data_wr && CFG_BE[0]) begin
        if (index_reg == hotplug_pkg::IDX_SLOT_POWER_ENABLE) begin
          pend_enable_reg <= CFG_WDATA[NS-1:0];
        end else if (index_reg == hotplug_pkg::IDX_SLOT_INDICATOR) begin
          pend_amber_reg <= CFG_WDATA[NS-1:0];
        end
      end
      // button toggles the shadow too, so a later commit does not undo it
      for (int i = 0; i < NS; i++) begin
        if (press[i] && !(data_wr && CFG_BE[0])) begin
          pend_enable_reg[i] <= ~target_reg[i];
        end
      end
    end
  end

  // committed controls, faults and button requests
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      target_reg      <= hotplug_pkg::SLOT_RESET;
      amber_cmt_reg   <= hotplug_pkg::SLOT_RESET;
      fault_lat_reg   <= hotplug_pkg::SLOT_RESET;
      commit_seen_reg <= 1'b0;
    end else begin
      if (commit) begin
        target_reg      <= data_wr && CFG_BE[0] ? CFG_WDATA[NS-1:0] : pend_enable_reg;
        amber_cmt_reg   <= pend_amber_reg;
        commit_seen_reg <= 1'b1;
      end
      for (int i = 0; i < NS; i++) begin
        // interlock pin is grounded on the board, so it never blocks a press
        if (press[i]) begin
          target_reg[i] <= ~target_reg[i];
        end
        if (fault_now[i]) begin
          target_reg[i]    <= 1'b0;
          fault_lat_reg[i] <= 1'b1;
        end else if (fault_clr[i]) begin
          fault_lat_reg[i] <= 1'b0;
        end
      end
    end
  end

  // per slot sequencing: power, then connect, then reset release
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      for (int i = 0; i < NS; i++) begin
        state_reg[i] <= hotplug_pkg::ST_OFF;
        timer_reg[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < NS; i++) begin
        if (timer_reg[i] != 16'h0000) begin
          timer_reg[i] <= timer_reg[i] - 16'h0001;
        end
        if (fault_now[i]) begin
          state_reg[i] <= hotplug_pkg::ST_OFF;
          timer_reg[i] <= 16'h0000;
        end else begin
          case (state_reg[i])
            hotplug_pkg::ST_OFF: begin
              if (target_reg[i] && init_ok_reg && !fault_lat_reg[i]) begin
                state_reg[i] <= hotplug_pkg::ST_PWRUP;
                timer_reg[i] <= hotplug_pkg::T_POWER_CYC;
              end
            end
            hotplug_pkg::ST_PWRUP: begin
              if (timer_reg[i] == 16'h0000) begin
                state_reg[i] <= hotplug_pkg::ST_CONNECT;
                timer_reg[i] <= hotplug_pkg::T_RESET_CYC;
              end
            end
            hotplug_pkg::ST_CONNECT: begin
              if (timer_reg[i] == 16'h0000) begin
                state_reg[i] <= hotplug_pkg::ST_ON;
              end
            end
            hotplug_pkg::ST_ON: begin
              if (!target_reg[i]) begin
                state_reg[i] <= hotplug_pkg::ST_RSTDN;
                timer_reg[i] <= hotplug_pkg::T_RESET_CYC;
              end
            end
            hotplug_pkg::ST_RSTDN: begin
              if (timer_reg[i] == 16'h0000) begin
                state_reg[i] <= hotplug_pkg::ST_DISC;
                timer_reg[i] <= hotplug_pkg::T_LINK_CYC;
              end
            end
            hotplug_pkg::ST_DISC: begin
              if (timer_reg[i] == 16'h0000) begin
                state_reg[i] <= hotplug_pkg::ST_PWROFF;
                timer_reg[i] <= hotplug_pkg::T_POWER_CYC;
              end
            end
            default: begin
              if (timer_reg[i] == 16'h0000) begin
                state_reg[i] <= hotplug_pkg::ST_OFF;
              end
            end
          endcase
        end
      end
    end
  end

  // bus speed
  logic [NS-1:0] linked;
  logic [NS-1:0] adding;
  always_comb begin
    for (int i = 0; i < NS; i++) begin
      linked[i] = is_linked(state_reg[i]);
      adding[i] = (state_reg[i] == hotplug_pkg::ST_PWRUP) && (timer_reg[i] == 16'h0000) &&
                  !fault_now[i];
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      bus_66_reg  <= 1'b0;
      spd_err_reg <= 1'b0;
    end else begin
      if (seg_b_reg) begin
        bus_66_reg <= 1'b0;
      end else if (linked == '0) begin
        bus_66_reg <= misc_reg[hotplug_pkg::MISC_SETUP_66_BIT];
      end else if (bus_66_reg && ((adding & ~m66) != '0)) begin
        bus_66_reg <= 1'b0;
      end
      // a new error wins over a clear in the same cycle
      if (!seg_b_reg && bus_66_reg && (linked != '0) && ((adding & ~m66) != '0)) begin
        spd_err_reg <= 1'b1;
      end else if (spd_clr) begin
        spd_err_reg <= 1'b0;
      end
    end
  end

  // blink divider, blink_reg toggles once per half period
  logic [25:0] blink_cnt_reg;
  logic        blink_reg;
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      blink_cnt_reg <= 26'h000_0000;
      blink_reg     <= 1'b0;
    end else if (blink_cnt_reg >= 26'(BLINK_HALF_CYC - 1)) begin
      blink_cnt_reg <= 26'h000_0000;
      blink_reg     <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 26'h000_0001;
    end
  end

  // registered pin outputs
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      SLOT_POWER_EN    <= '0;
      SLOT_BUS_CONNECT <= '0;
      SLOT_RESET_N     <= '0;
      LED_GREEN        <= '0;
      LED_AMBER        <= '0;
      DUMMY_CYCLE_EN   <= 1'b0;
      BUS_66_EN        <= 1'b0;
      SPEED_ERROR      <= 1'b0;
      INIT_DONE        <= 1'b0;
    end else begin
      for (int i = 0; i < NS; i++) begin
        SLOT_POWER_EN[i]    <= power_now[i] && !fault_now[i];
        SLOT_BUS_CONNECT[i] <= linked[i] && !fault_now[i];
        SLOT_RESET_N[i]     <= state_reg[i] == hotplug_pkg::ST_ON;
        if (state_reg[i] == hotplug_pkg::ST_ON) begin
          LED_GREEN[i] <= 1'b1;
          LED_AMBER[i] <= amber_cmt_reg[i] || fault_lat_reg[i];
        end else if (state_reg[i] == hotplug_pkg::ST_OFF) begin
          LED_GREEN[i] <= 1'b0;
          LED_AMBER[i] <= amber_cmt_reg[i] || fault_lat_reg[i];
        end else begin
          LED_GREEN[i] <= blink_reg;
          LED_AMBER[i] <= 1'b0;
        end
      end
      DUMMY_CYCLE_EN <= (state_reg[0] inside {hotplug_pkg::ST_CONNECT,
                         hotplug_pkg::ST_RSTDN, hotplug_pkg::ST_DISC}) ||
                        (state_reg[1] inside {hotplug_pkg::ST_CONNECT,
                         hotplug_pkg::ST_RSTDN, hotplug_pkg::ST_DISC}) ||
                        (state_reg[2] inside {hotplug_pkg::ST_CONNECT,
                         hotplug_pkg::ST_RSTDN, hotplug_pkg::ST_DISC}) ||
                        (state_reg[3] inside {hotplug_pkg::ST_CONNECT,
                         hotplug_pkg::ST_RSTDN, hotplug_pkg::ST_DISC});
      BUS_66_EN   <= bus_66_reg;
      SPEED_ERROR <= spd_err_reg;
      INIT_DONE   <= init_ok_reg && commit_seen_reg &&
                     ((linked | ~power_now) == '1) &&
                     (DUMMY_CYCLE_EN == 1'b0);
    end
  end
endmodule
`default_nettype wire

// ### bench/slot_cards.sv
// behavioural model of the add-in cards that sit in the four slots
`default_nettype none
module slot_cards (
  // card population and behaviour chosen by the bench
  input  wire logic [3:0] insert,
  input  wire logic [3:0] cap66,
  input  wire logic [3:0] short_req,
  // slot power seen by the cards
  input  wire logic [3:0] power_en,
  // card pins toward the controller
  output logic      [3:0] present,
  output logic      [3:0] m66en,
  output logic      [3:0] fault
);
  timeunit 1ns;
  timeprecision 1ps;
  assign present = insert;
  // the capability line is pulled up, so an empty slot reads as 66 capable
  assign m66en = (insert & cap66) | ~insert;
  // an overload draws current only while the slot is powered
  assign fault = short_req & power_en;
endmodule
`default_nettype wire

// ### bench/hotplug_checker_assertions.sv
// concurrent checks on the slot controller ports
`default_nettype none
module hotplug_checker_assertions #(
  parameter int unsigned BLINK_HALF_CYC = 4
) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        SYS_RST,
  // configuration access
  input wire logic        CFG_REQ,
  input wire logic        CFG_WR,
  input wire logic [4:0]  CFG_DEV,
  input wire logic [7:0]  CFG_ADDR,
  input wire logic [3:0]  CFG_BE,
  input wire logic [31:0] CFG_WDATA,
  input wire logic [31:0] CFG_RDATA,
  input wire logic        CFG_ACK,
  input wire logic        SEGMENT_B_SEL,
  // slot pins and bus level
  input wire logic [3:0]  SLOT_FAULT,
  input wire logic [3:0]  SLOT_POWER_EN,
  input wire logic [3:0]  SLOT_BUS_CONNECT,
  input wire logic [3:0]  SLOT_RESET_N,
  input wire logic [3:0]  LED_GREEN,
  input wire logic [3:0]  LED_AMBER,
  input wire logic        DUMMY_CYCLE_EN,
  input wire logic        BUS_66_EN,
  input wire logic        SPEED_ERROR
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  logic hit;
  logic win_reg;
  assign hit = CFG_REQ && (CFG_DEV == (SEGMENT_B_SEL ? 5'h05 : 5'h07));
  // shadow of the window enable, so refused reads can be judged
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      win_reg <= 1'b0;
    end else if (hit && CFG_WR && CFG_ADDR[7:2] == 6'h10 && CFG_BE[2]) begin
      win_reg <= CFG_WDATA[hotplug_pkg::MISC_WINDOW_EN_BIT];
    end
  end
  AST_CONNECT_LAST: assert property ((SLOT_BUS_CONNECT & ~SLOT_POWER_EN) == 4'h0)
    else $error("bus connected to an unpowered slot");
  AST_POWER_SETTLED: assert property (
    $rose(SLOT_BUS_CONNECT[0]) |-> $past(SLOT_POWER_EN[0], 200))
    else $error("slot connected before power settled");
  AST_RESET_RELEASE: assert property (
    $rose(SLOT_RESET_N[0]) |-> $past(SLOT_BUS_CONNECT[0], 200))
    else $error("card reset released too early");
  AST_DUMMY: assert property (|(SLOT_BUS_CONNECT & ~SLOT_RESET_N) |-> DUMMY_CYCLE_EN)
    else $error("no dummy cycles during slot transition");
  AST_AMBER_TRANS: assert property ((SLOT_POWER_EN & ~SLOT_RESET_N & LED_AMBER) == 4'h0)
    else $error("amber lit while power changes");
  AST_GREEN_ON: assert property (SLOT_RESET_N[0] |-> LED_GREEN[0])
    else $error("green not steady on a running slot");
  AST_FAULT_OFF: assert property (SLOT_FAULT[1] |-> ##[1:5] !SLOT_POWER_EN[1])
    else $error("power kept after slot fault");
  AST_SPEED_DROP: assert property ($rose(SPEED_ERROR) |-> ##[0:2] !BUS_66_EN)
    else $error("speed error without drop to 33");
  AST_ACK_HIT: assert property (hit |=> CFG_ACK ##1 (CFG_ACK == $past(hit)))
    else $error("config hit not acknowledged once");
  AST_ACK_CAUSE: assert property (CFG_ACK |-> $past(hit))
    else $error("acknowledge without own device access");
  AST_WINDOW_OFF: assert property (
    hit && !CFG_WR && !win_reg && CFG_ADDR[7:4] == 4'h5 |=> CFG_RDATA == 32'h0)
    else $error("window readable while disabled");
endmodule
bind live_insertion_controller hotplug_checker_assertions #(
  .BLINK_HALF_CYC(BLINK_HALF_CYC)
) u_hotplug_checker_assertions (
  .CLK(CLK), .SYS_RST(SYS_RST), .CFG_REQ(CFG_REQ), .CFG_WR(CFG_WR), .CFG_DEV(CFG_DEV),
  .CFG_ADDR(CFG_ADDR), .CFG_BE(CFG_BE), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
  .CFG_ACK(CFG_ACK), .SEGMENT_B_SEL(SEGMENT_B_SEL), .SLOT_FAULT(SLOT_FAULT),
  .SLOT_POWER_EN(SLOT_POWER_EN), .SLOT_BUS_CONNECT(SLOT_BUS_CONNECT),
  .SLOT_RESET_N(SLOT_RESET_N), .LED_GREEN(LED_GREEN), .LED_AMBER(LED_AMBER),
  .DUMMY_CYCLE_EN(DUMMY_CYCLE_EN), .BUS_66_EN(BUS_66_EN), .SPEED_ERROR(SPEED_ERROR)
);
`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the live insertion slot controller
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        rst;
  logic        req;
  logic        wr;
  logic [4:0]  dev;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  logic [31:0] rdata_q;
  logic        ack_q;
  logic [3:0]  btn_n;
  logic [3:0]  insert;
  logic [3:0]  cap66;
  logic [3:0]  short_req;
  logic [3:0]  present;
  logic [3:0]  m66en;
  logic [3:0]  fault;
  logic [3:0]  power_en;
  logic [3:0]  connect;
  logic [3:0]  reset_n;
  logic [3:0]  green;
  logic [3:0]  amber;
  logic        dummy;
  logic        bus66;
  logic        spd_err;
  logic        seg_b;
  logic        peer;
  logic        init_done;
  logic        g;
  int          n;
  int          fail_count = 0;
  int          tests_run = 0;
  live_insertion_controller #(.BLINK_HALF_CYC(4)) u_live_insertion_controller (
    .CLK(clk), .SYS_RST(rst), .CFG_REQ(req), .CFG_WR(wr), .CFG_DEV(dev), .CFG_ADDR(addr),
    .CFG_BE(4'hf), .CFG_WDATA(wdata), .CFG_RDATA(rdata), .CFG_ACK(ack),
    .SEGMENT_B_SEL(seg_b), .PEER_INIT_DONE(peer), .INIT_DONE(init_done),
    .SLOT_BUTTON_N(btn_n), .SLOT_PRESENT(present), .SLOT_FAULT(fault), .SLOT_M66EN(m66en),
    .SLOT_POWER_EN(power_en), .SLOT_BUS_CONNECT(connect), .SLOT_RESET_N(reset_n),
    .LED_GREEN(green), .LED_AMBER(amber), .DUMMY_CYCLE_EN(dummy), .BUS_66_EN(bus66),
    .SPEED_ERROR(spd_err));
  slot_cards u_slot_cards (.insert(insert), .cap66(cap66), .short_req(short_req),
    .power_en(power_en), .present(present), .m66en(m66en), .fault(fault));
  task automatic results;
    if (fail_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wt(input int c);
    repeat (c) @(negedge clk);
  endtask
  // one-cycle request; answer is sampled a cycle later while it stands
  task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(negedge clk);
    req = 1'b1;
    wr = w;
    addr = a;
    wdata = v;
    @(negedge clk);
    req = 1'b0;
    ack_q = ack;
    rdata_q = rdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    cfg(1'b0, a, 32'h0);
    `CHK("cfg ack", 1'b1, ack_q)
    `CHK("cfg read", e, rdata_q)
  endtask
  task automatic press(input int s);
    btn_n[s] = 1'b0;
    wt(4);
    btn_n[s] = 1'b1;
  endtask
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // the sequence needs about 3000 cycles
  initial begin
    #(20000 * 4);
    fail_count++;
    results();
  end
  initial begin
    rst = 1'b1;
    req = 1'b0;
    wr = 1'b0;
    dev = 5'h07;
    addr = 8'h00;
    wdata = 32'h0;
    btn_n = 4'hf;
    insert = 4'h3;
    cap66 = 4'h1;
    short_req = 4'h0;
    seg_b = 1'b0;
    peer = 1'b1;
    wt(6);
    rst = 1'b0;
    wt(4);
    `CHK("cards in reset", 4'h0, reset_n)
    rd(8'h00, hotplug_pkg::ID_VALUE);
    dev = 5'h05;
    cfg(1'b0, 8'h00, 32'h0);
    `CHK("foreign device ack", 1'b0, ack_q)
    dev = 5'h07;
    rd(8'h54, 32'h0);
    cfg(1'b1, 8'h50, 32'h4);
    cfg(1'b1, 8'h40, 32'h0080_0001);
    rd(8'h50, 32'h0);
    rd(8'h40, 32'h0080_0001);
    cfg(1'b1, 8'h50, 32'h0);
    cfg(1'b1, 8'h54, 32'h0000_0002);
    wt(20);
    `CHK("uncommitted power", 5'h00, {power_en, init_done})
    rd(8'h54, 32'h0000_0002);
    // only the populated slot 0 is switched on
    cfg(1'b1, 8'h54, 32'h0001_0001);
    wt(10);
    `CHK("power before link", 8'h01, {connect, power_en})
    g = green[0];
    n = 0;
    repeat (16) begin
      wt(1);
      if (green[0] !== g) n++;
      g = green[0];
    end
    `CHK("green blink toggles", 4, n)
    `CHK("amber in transition", 1'b0, amber[0])
    wt(270);
    `CHK("link with card in reset", 2'b10, {connect[0], reset_n[0]})
    `CHK("dummy cycles", 1'b1, dummy)
    wt(260);
    `CHK("slot on", 6'b110011, {reset_n[0], green[0], amber[0], dummy, bus66, init_done})
    cfg(1'b1, 8'h54, 32'h0001_0003);
    wt(570);
    `CHK("33 card on 66 bus", 2'b01, {bus66, spd_err})
    cfg(1'b1, 8'h50, 32'h8);
    rd(8'h54, 32'h0000_1033);
    cfg(1'b1, 8'h50, 32'h4);
    cfg(1'b1, 8'h54, 32'h1);
    cfg(1'b1, 8'h50, 32'h0);
    cfg(1'b1, 8'h54, 32'h0001_0003);
    wt(4);
    `CHK("attention on", 2'b11, {green[0], amber[0]})
    short_req = 4'h2;
    wt(8);
    `CHK("fault removes power", 3'b001, {power_en[1], green[1], amber[1]})
    short_req = 4'h0;
    wt(30);
    `CHK("fault amber held", 1'b1, amber[1])
    cfg(1'b1, 8'h50, 32'h8);
    cfg(1'b1, 8'h54, 32'h0000_0200);
    wt(4);
    `CHK("fault amber cleared", 1'b0, amber[1])
    press(2);
    wt(10);
    `CHK("button powers empty slot", 1'b1, power_en[2])
    wt(560);
    `CHK("button slot on", 1'b1, reset_n[2])
    press(2);
    wt(10);
    `CHK("reset before unlink", 2'b10, {connect[2], reset_n[2]})
    wt(300);
    `CHK("unlink before power off", 2'b01, {connect[2], power_en[2]})
    wt(320);
    `CHK("button powers off", 2'b00, {power_en[2], green[2]})
    // second segment: fixed 33 MHz even with a 66 setup, waits for its peer
    seg_b = 1'b1;
    peer = 1'b0;
    rst = 1'b1;
    wt(6);
    rst = 1'b0;
    wt(4);
    dev = 5'h05;
    cfg(1'b1, 8'h40, 32'h0080_0001);
    cfg(1'b1, 8'h50, 32'h0);
    cfg(1'b1, 8'h54, 32'h0001_0001);
    wt(20);
    `CHK("wait for peer", 2'b00, {power_en[0], bus66})
    peer = 1'b1;
    wt(10);
    `CHK("power after peer", 1'b1, power_en[0])
    wt(530);
    `CHK("segment b at 33", 2'b10, {reset_n[0], bus66})
    results();
  end
endmodule
`default_nettype wire
